// [hw/lmcd_top.sv]
/*
 * Motion command decoder: turns bus frames into position, parameter, halt,
 * sleep and back-EMF routing actions, with an APB register slave.
 * Assumes frames arrive from a data-link layer on MCLK; motion state comes
 * from the position controller; pins and thermal flag are asynchronous.
 */
`default_nettype none
`include "lmcd_consts.svh"

// Function
// - Move-with-params uses a four data byte frame with its assigned identifier
// - Move target is signed 16 bits, high byte first
// - Byte 3 gives max/min velocity, byte 4 stall threshold/acceleration
// - Sleep is identifier 0x3C, first byte 0x00, rest 0xFF
// - Sleep while moving: target from secure position, else gentle halt, then sleep
// - Gentle halt decelerates to minimum velocity and stops
// - After halt stops, target takes actual position
// - Gentle halt ignored during two-stage reference run; a sleep frame while moving without secure position still halts
// - Over-temperature raises a gentle halt internally
// - Halt frame: two bytes, code 0x0F with bit 7, broadcast plus node
// - Broadcast flag zero makes every node act
// - Probe frame code 0x1F routes back-EMF to switch pin
// - Back-EMF routing stays on until power-on reset
// - Switch pin sampling suppressed while back-EMF routing active
// - Identifier top two bits are parity, checked on receive
module lmcd_top
    import lmcd_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        MCLK,
    input  wire logic        RESET,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Received frames
    input  wire logic        FRM_VALID,
    input  wire logic [3:0]  FRM_LEN,
    input  wire logic [7:0]  FRM_ID,
    input  wire logic [63:0] FRM_DATA,
    // Position controller
    input  wire logic [15:0] ACT_POS,
    input  wire logic [10:0] SEC_POS,
    input  wire logic        MOTION_BUSY,
    input  wire logic        REF_RUN_BUSY,
    output logic      [15:0] TARGET_POS,
    output logic      [3:0]  VMAX_IDX,
    output logic      [3:0]  VMIN_IDX,
    output logic      [3:0]  STALL_THR_IDX,
    output logic      [3:0]  ACC_IDX,
    output logic             GENTLE_HALT,
    output logic             SLEEP_REQ,
    // Asynchronous inputs
    input  wire logic        OVER_TEMP,
    input  wire logic        BEMF_IN,
    // Switch input pin
    input  wire logic        SWI_I,
    output logic             SWI_O,
    output logic             SWI_OE,
    output logic             SWI_LEVEL
);
    localparam int NSYNC = 3;

    lmcd_dec_if dec ();

    logic [6:0]        node_ad_r;
    logic [6:0]        node_ad_nxt;
    logic [5:0]        move_id_r;
    logic [5:0]        move_id_nxt;
    logic [5:0]        t1_id_r;
    logic [5:0]        t1_id_nxt;
    logic              pready_r;
    logic              pready_nxt;
    logic              pslverr_r;
    logic              pslverr_nxt;
    logic [31:0]       prdata_r;
    logic [31:0]       prdata_nxt;
    logic              apb_wr;
    logic              addr_ok;

    logic [NSYNC-1:0]  s1_r;
    logic [NSYNC-1:0]  s2_r;
    logic [NSYNC-1:0]  s3_r;
    logic [NSYNC-1:0]  filt_r;
    logic [NSYNC-1:0]  filt_nxt;

    lmcd_state_t       state_r;
    lmcd_state_t       state_nxt;
    logic [15:0]       target_r;
    logic [15:0]       target_nxt;
    logic [15:0]       prm_r;
    logic [15:0]       prm_nxt;
    logic              sleep_pend_r;
    logic              sleep_pend_nxt;
    logic              ot_prev_r;
    logic              bemf_on_r;
    logic              bemf_on_nxt;
    logic              swi_lvl_r;
    logic              swi_lvl_nxt;
    logic              swi_o_r;
    logic              halt_req;
    logic              gentle_halt_r;
    logic              gentle_halt_nxt;
    logic              sleep_req_r;
    logic              sleep_req_nxt;

    // ==================================================================
    // Frame classifier
    lmcd_frame_check u_check (
        .frm_valid (FRM_VALID),
        .frm_len   (FRM_LEN),
        .frm_id    (FRM_ID),
        .frm_data  (FRM_DATA),
        .node_ad   (node_ad_r),
        .move_id   (move_id_r),
        .t1_id     (t1_id_r),
        .dec       (dec)
    );

    // ==================================================================
    // APB slave: one wait state, so every output is a flop
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `LMCD_OFS_NODE) || (a == `LMCD_OFS_IDS)
                 || (a == `LMCD_OFS_STATUS) || (a == `LMCD_OFS_TARGET)
                 || (a == `LMCD_OFS_PARAMS);
    endfunction

    always_comb begin
        addr_ok     = is_mapped(PADDR);
        apb_wr      = PSEL && PENABLE && pready_r && PWRITE && addr_ok;
        pready_nxt  = PSEL && PENABLE && !pready_r;
        pslverr_nxt = pready_nxt && !addr_ok;
        node_ad_nxt = node_ad_r;
        move_id_nxt = move_id_r;
        t1_id_nxt   = t1_id_r;
        prdata_nxt  = 32'h00000000;
        if (apb_wr && (PADDR == `LMCD_OFS_NODE)) begin
            node_ad_nxt = PWDATA[6:0];
        end
        if (apb_wr && (PADDR == `LMCD_OFS_IDS)) begin
            move_id_nxt = PWDATA[5:0];
            t1_id_nxt   = PWDATA[13:8];
        end
        if (pready_nxt && !PWRITE) begin
            unique case (PADDR)
                `LMCD_OFS_NODE:   prdata_nxt = {25'h0000000, node_ad_r};
                `LMCD_OFS_IDS:    prdata_nxt = {18'h00000, t1_id_r, 2'h0, move_id_r};
                `LMCD_OFS_STATUS: prdata_nxt = {26'h0000000, sleep_pend_r, swi_lvl_r,
                                                bemf_on_r, filt_r[0], state_r};
                `LMCD_OFS_TARGET: prdata_nxt = {16'h0000, target_r};
                `LMCD_OFS_PARAMS: prdata_nxt = {16'h0000, prm_r};
                default:          prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            node_ad_r <= `LMCD_NODE_RST;
            move_id_r <= `LMCD_MOVE_ID_RST;
            t1_id_r   <= `LMCD_T1_ID_RST;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else if (CE) begin
            node_ad_r <= node_ad_nxt;
            move_id_r <= move_id_nxt;
            t1_id_r   <= t1_id_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // ==================================================================
    // Asynchronous inputs: bit 0 thermal, 1 back-EMF, 2 switch pin
    // A change is taken only once the second and third stages agree
    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            logic raw;
            assign raw = (i == 0) ? OVER_TEMP : ((i == 1) ? BEMF_IN : SWI_I);
            always_comb begin
                filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
            end
            always_ff @(posedge MCLK) begin
                if (RESET) begin
                    s1_r[i]   <= 1'b0;
                    s2_r[i]   <= 1'b0;
                    s3_r[i]   <= 1'b0;
                    filt_r[i] <= 1'b0;
                end else if (CE) begin
                    s1_r[i]   <= raw;
                    s2_r[i]   <= s1_r[i];
                    s3_r[i]   <= s2_r[i];
                    filt_r[i] <= filt_nxt[i];
                end
            end
        end
    endgenerate

    // ==================================================================
    // Halt, sleep and move sequencer
    always_comb begin
        state_nxt      = state_r;
        target_nxt     = target_r;
        prm_nxt        = prm_r;
        sleep_pend_nxt = sleep_pend_r;
        halt_req       = (dec.is_halt || (filt_r[0] && !ot_prev_r))
                      && MOTION_BUSY && !REF_RUN_BUSY;
        unique case (state_r)
            ST_RUN: begin
                if (dec.is_move) begin
                    target_nxt = dec.pos;
                    prm_nxt    = dec.prm;
                end
                if (dec.is_sleep && !MOTION_BUSY) begin
                    state_nxt = ST_SLEEP;
                end else if (dec.is_sleep && (SEC_POS != `LMCD_SEC_NONE)) begin
                    target_nxt     = {{5{SEC_POS[10]}}, SEC_POS};
                    sleep_pend_nxt = 1'b1;
                end else if (dec.is_sleep) begin
                    sleep_pend_nxt = 1'b1;
                    state_nxt      = ST_HALT;
                end else if (halt_req) begin
                    state_nxt = ST_HALT;
                end else if (sleep_pend_r && !MOTION_BUSY) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_HALT: begin
                if (dec.is_sleep) begin
                    sleep_pend_nxt = 1'b1;
                end
                if (!MOTION_BUSY) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                target_nxt = ACT_POS;
                state_nxt  = (sleep_pend_r || dec.is_sleep) ? ST_SLEEP : ST_RUN;
            end
            ST_SLEEP: begin
                state_nxt = ST_SLEEP;
            end
        endcase
        // Decoded ahead so both level outputs leave straight from flops
        gentle_halt_nxt = (state_nxt == ST_HALT);
        sleep_req_nxt   = (state_nxt == ST_SLEEP);
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_r      <= ST_RUN;
            target_r     <= `LMCD_TARGET_RST;
            prm_r        <= `LMCD_PARAMS_RST;
            sleep_pend_r <= 1'b0;
            ot_prev_r    <= 1'b0;
            gentle_halt_r <= 1'b0;
            sleep_req_r  <= 1'b0;
        end else if (CE) begin
            state_r      <= state_nxt;
            target_r     <= target_nxt;
            prm_r        <= prm_nxt;
            sleep_pend_r <= sleep_pend_nxt;
            ot_prev_r    <= filt_r[0];
            gentle_halt_r <= gentle_halt_nxt;
            sleep_req_r  <= sleep_req_nxt;
        end
    end

    // ==================================================================
    // Back-EMF routing and switch sampling
    // Only reset clears the routing; no frame can turn it off
    always_comb begin
        bemf_on_nxt = bemf_on_r || dec.is_probe;
        swi_lvl_nxt = bemf_on_r ? swi_lvl_r : filt_r[2];
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            bemf_on_r <= 1'b0;
            swi_lvl_r <= 1'b0;
            swi_o_r   <= 1'b0;
        end else if (CE) begin
            bemf_on_r <= bemf_on_nxt;
            swi_lvl_r <= swi_lvl_nxt;
            swi_o_r   <= bemf_on_nxt && filt_r[1];
        end
    end

    // ==================================================================
    // Outputs
    assign PRDATA        = prdata_r;
    assign PREADY        = pready_r;
    assign PSLVERR       = pslverr_r;
    assign TARGET_POS    = target_r;
    assign VMAX_IDX      = prm_r[7:4];
    assign VMIN_IDX      = prm_r[3:0];
    assign STALL_THR_IDX = prm_r[15:12];
    assign ACC_IDX       = prm_r[11:8];
    assign GENTLE_HALT   = gentle_halt_r;
    assign SLEEP_REQ     = sleep_req_r;
    assign SWI_O         = swi_o_r;
    assign SWI_OE        = bemf_on_r;
    assign SWI_LEVEL     = swi_lvl_r;
endmodule

`default_nettype wire

// [hw/lmcd_consts.svh]
/*
 * Offsets, field values, reset values and frame codes of the motion command decoder.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef LMCD_CONSTS_SVH
`define LMCD_CONSTS_SVH

// ======================================================================
// Register offsets (byte addresses)
`define LMCD_OFS_NODE    8'h00
`define LMCD_OFS_IDS     8'h04
`define LMCD_OFS_STATUS  8'h08
`define LMCD_OFS_TARGET  8'h0C
`define LMCD_OFS_PARAMS  8'h10

// ======================================================================
// Reset values
`define LMCD_NODE_RST    7'h00
`define LMCD_MOVE_ID_RST 6'h00
`define LMCD_T1_ID_RST   6'h00
`define LMCD_TARGET_RST  16'h0000
`define LMCD_PARAMS_RST  16'h0000

// ======================================================================
// Frame codes
`define LMCD_SLEEP_ID    8'h3C
`define LMCD_SLEEP_FIRST 8'h00
`define LMCD_FILL        8'hFF
`define LMCD_CMD_HALT    7'h0F
`define LMCD_CMD_PROBE   7'h1F
`define LMCD_LEN_MOVE    4'h4
`define LMCD_LEN_T1      4'h2
`define LMCD_LEN_SLEEP   4'h8
`define LMCD_SEC_NONE    11'h400

`endif

// [hw/lmcd_pkg.sv]
/*
 * Types of the motion command decoder.
 * Assumes the constants header is on the include path.
 */
`default_nettype none

package lmcd_pkg;
    // ==================================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_HALT  = 2'b01,
        ST_HOLD  = 2'b10,
        ST_SLEEP = 2'b11
    } lmcd_state_t;
endpackage

`default_nettype wire

// [hw/lmcd_dec_if.sv]
/*
 * Carrier between the frame checker and the decoder top.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface lmcd_dec_if;
    logic        is_move;
    logic        is_sleep;
    logic        is_halt;
    logic        is_probe;
    logic [15:0] pos;
    logic [15:0] prm;

    modport prod (output is_move, is_sleep, is_halt, is_probe, pos, prm);
    modport cons (input is_move, is_sleep, is_halt, is_probe, pos, prm);
endinterface

`default_nettype wire

// [hw/lmcd_frame_check.sv]
/*
 * Combinational classifier of received frames: identifier parity, frame kind, addressing.
 * Assumes frame fields are stable in the cycle in which the valid strobe is high.
 */
`default_nettype none
`include "lmcd_consts.svh"

module lmcd_frame_check
    import lmcd_pkg::*;
(
    // Frame from the data-link layer
    input wire logic        frm_valid,
    input wire logic [3:0]  frm_len,
    input wire logic [7:0]  frm_id,
    input wire logic [63:0] frm_data,
    // Programmed identity
    input wire logic [6:0]  node_ad,
    input wire logic [5:0]  move_id,
    input wire logic [5:0]  t1_id,
    // Decoded result
    lmcd_dec_if.prod        dec
);
    // ==================================================================
    // Helpers
    function automatic logic par_ok(input logic [7:0] b);
        par_ok = (b[6] == (b[0] ^ b[1] ^ b[2] ^ b[4]))
              && (b[7] == ~(b[1] ^ b[3] ^ b[4] ^ b[5]));
    endfunction

    // Broadcast '0' reaches every node; '1' needs the own node number
    function automatic logic addr_hit(input logic [7:0] b, input logic [6:0] ad);
        addr_hit = !b[7] || (b[6:0] == ad);
    endfunction

    logic       id_ok;
    logic       t1_ok;
    logic       fill_ok;
    logic [7:0] d1;
    logic [7:0] d2;

    // ==================================================================
    // Classification
    always_comb begin
        d1      = frm_data[7:0];
        d2      = frm_data[15:8];
        id_ok   = frm_valid && par_ok(frm_id);
        t1_ok   = id_ok && !frm_id[5] && (frm_id[5:0] == t1_id)
               && (frm_len == `LMCD_LEN_T1) && d1[7] && addr_hit(d2, node_ad);
        fill_ok = (frm_data[63:8] == {7{`LMCD_FILL}});
        dec.is_move  = id_ok && (frm_id[5:0] == move_id)
                    && (frm_len == `LMCD_LEN_MOVE);
        dec.is_sleep = frm_valid && (frm_id == `LMCD_SLEEP_ID)
                    && (frm_len == `LMCD_LEN_SLEEP)
                    && (d1 == `LMCD_SLEEP_FIRST) && fill_ok;
        dec.is_halt  = t1_ok && (d1[6:0] == `LMCD_CMD_HALT);
        dec.is_probe = t1_ok && (d1[6:0] == `LMCD_CMD_PROBE);
        dec.pos      = {d1, d2};
        dec.prm      = frm_data[31:16];
    end
endmodule

`default_nettype wire

// [tb/lmcd_checker.sv]
/*
 * Concurrent checks on the motion command decoder top ports.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`default_nettype none

module lmcd_checker (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RESET,
    // Frames
    input wire logic        FRM_VALID,
    input wire logic [3:0]  FRM_LEN,
    input wire logic [7:0]  FRM_ID,
    input wire logic [63:0] FRM_DATA,
    // Position controller
    input wire logic [15:0] ACT_POS,
    input wire logic        MOTION_BUSY,
    input wire logic        REF_RUN_BUSY,
    input wire logic        OVER_TEMP,
    input wire logic [15:0] TARGET_POS,
    input wire logic [3:0]  VMAX_IDX,
    input wire logic [3:0]  ACC_IDX,
    input wire logic        GENTLE_HALT,
    input wire logic        SLEEP_REQ,
    // Switch pin
    input wire logic        SWI_OE,
    input wire logic        SWI_LEVEL
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // Properties
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    a_pos_bytes: assert property ($changed(TARGET_POS) && $past(FRM_VALID) && $past(FRM_LEN) == 4'h4
        |-> TARGET_POS == {$past(FRM_DATA[7:0]), $past(FRM_DATA[15:8])})
        else $error("target not built from bytes 1 and 2");
    a_param_nibbles: assert property (($changed(VMAX_IDX) || $changed(ACC_IDX)) |-> $past(FRM_VALID)
        && VMAX_IDX == $past(FRM_DATA[23:20]) && ACC_IDX == $past(FRM_DATA[27:24]))
        else $error("parameter nibbles misplaced");
    a_sleep_idle: assert property (FRM_VALID && FRM_ID == 8'h3C && FRM_LEN == 4'h8
        && FRM_DATA == 64'hFFFFFFFFFFFFFF00 && !MOTION_BUSY && !GENTLE_HALT
        |-> ##[1:3] SLEEP_REQ)
        else $error("sleep frame not honoured");
    a_sleep_sticky: assert property (SLEEP_REQ |=> SLEEP_REQ)
        else $error("sleep request dropped");
    a_halt_decel: assert property (GENTLE_HALT && MOTION_BUSY |=> GENTLE_HALT)
        else $error("halt released while moving");
    a_halt_target: assert property ($fell(GENTLE_HALT) |=> TARGET_POS == $past(ACT_POS))
        else $error("target not loaded from actual position");
    a_ref_run_ignore: assert property (REF_RUN_BUSY && !GENTLE_HALT |=> !GENTLE_HALT)
        else $error("halt during reference run");
    a_thermal_halt: assert property ($rose(OVER_TEMP) && MOTION_BUSY && !REF_RUN_BUSY
        |-> ##[1:8] GENTLE_HALT)
        else $error("no halt on over-temperature");
    a_bemf_sticky: assert property (SWI_OE |=> SWI_OE)
        else $error("back-EMF routing cancelled");
    a_swi_frozen: assert property (SWI_OE |=> $stable(SWI_LEVEL))
        else $error("switch level sampled during probe");
endmodule

bind lmcd_top lmcd_checker lmcd_checker_i (.MCLK(MCLK), .RESET(RESET), .FRM_VALID(FRM_VALID),
    .FRM_LEN(FRM_LEN), .FRM_ID(FRM_ID), .FRM_DATA(FRM_DATA), .ACT_POS(ACT_POS),
    .MOTION_BUSY(MOTION_BUSY), .REF_RUN_BUSY(REF_RUN_BUSY), .OVER_TEMP(OVER_TEMP),
    .TARGET_POS(TARGET_POS), .VMAX_IDX(VMAX_IDX), .ACC_IDX(ACC_IDX), .GENTLE_HALT(GENTLE_HALT),
    .SLEEP_REQ(SLEEP_REQ), .SWI_OE(SWI_OE), .SWI_LEVEL(SWI_LEVEL));

`default_nettype wire

// [tb/lmcd_lin_master.sv]
/*
 * Bus master model: hands whole frames to the decoder as one-cycle strobes.
 * Assumes the data-link layer already delivered bytes on MCLK.
 */
`default_nettype none

module lmcd_lin_master (
    // Clock
    input wire logic        MCLK,
    // Frame out
    output var logic        FRM_VALID,
    output var logic [3:0]  FRM_LEN,
    output var logic [7:0]  FRM_ID,
    output var logic [63:0] FRM_DATA
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // Identifier protection
    function automatic logic [7:0] pid(input logic [5:0] i);
        return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
    endfunction

    initial begin
        FRM_VALID = 1'h0;
        FRM_LEN = 4'h0;
        FRM_ID = 8'h00;
        FRM_DATA = 64'h0;
    end

    // ==================================================================
    // Frame send; caller picks one id per motor and the lengths
    // Data lines are scrambled afterwards so stale bytes never look valid
    task automatic send(input logic [3:0] len, input logic [7:0] idb, input logic [63:0] d);
        @(posedge MCLK);
        FRM_VALID <= 1'h1;
        FRM_LEN <= len;
        FRM_ID <= idb;
        FRM_DATA <= d;
        @(posedge MCLK);
        FRM_VALID <= 1'h0;
        FRM_DATA <= ~d;
    endtask
endmodule

`default_nettype wire

// [tb/testbench.sv]
/*
 * Self-checking bench of the motion command decoder with a bus master model.
 * Assumes the checker is bound from its own file.
 */
`default_nettype none

module testbench;
    import lmcd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // Signals
    logic        MCLK = 1'h0, RESET = 1'h1, CE = 1'h1;
    logic        PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, PREADY, PSLVERR, FRM_VALID, er;
    logic [7:0]  PADDR = 8'h00, FRM_ID;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [3:0]  FRM_LEN, VMAX_IDX, VMIN_IDX, STALL_THR_IDX, ACC_IDX;
    logic [63:0] FRM_DATA;
    logic [15:0] ACT_POS = 16'h0, TARGET_POS, ep, eprm;
    logic [10:0] SEC_POS = 11'h0;
    logic        MOTION_BUSY = 1'h0, REF_RUN_BUSY = 1'h0, OVER_TEMP = 1'h0;
    logic        BEMF_IN = 1'h0, SWI_I = 1'h0;
    logic        GENTLE_HALT, SLEEP_REQ, SWI_O, SWI_OE, SWI_LEVEL;
    int          errors = 0, compares = 0, seed = 73235, i;

    always #10 MCLK = ~MCLK;

    lmcd_top lmcd_top_i (.MCLK(MCLK), .RESET(RESET), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .FRM_VALID(FRM_VALID), .FRM_LEN(FRM_LEN), .FRM_ID(FRM_ID),
        .FRM_DATA(FRM_DATA), .ACT_POS(ACT_POS), .SEC_POS(SEC_POS), .MOTION_BUSY(MOTION_BUSY),
        .REF_RUN_BUSY(REF_RUN_BUSY), .TARGET_POS(TARGET_POS), .VMAX_IDX(VMAX_IDX),
        .VMIN_IDX(VMIN_IDX), .STALL_THR_IDX(STALL_THR_IDX), .ACC_IDX(ACC_IDX),
        .GENTLE_HALT(GENTLE_HALT), .SLEEP_REQ(SLEEP_REQ), .OVER_TEMP(OVER_TEMP),
        .BEMF_IN(BEMF_IN), .SWI_I(SWI_I), .SWI_O(SWI_O), .SWI_OE(SWI_OE), .SWI_LEVEL(SWI_LEVEL));
    lmcd_lin_master lmcd_lin_master_i (.MCLK(MCLK), .FRM_VALID(FRM_VALID), .FRM_LEN(FRM_LEN),
        .FRM_ID(FRM_ID), .FRM_DATA(FRM_DATA));

    // ==================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'h1;
        do @(posedge MCLK); while (PREADY !== 1'h1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask

    task automatic fr(input logic [3:0] len, input logic [7:0] idb, input logic [63:0] d);
        lmcd_lin_master_i.send(len, idb, d);
        // Answer of the taking edge is read at the next edge, so drives stay on edges
        @(posedge MCLK);
    endtask

    task automatic wt(input logic k, input logic v);
        for (int n = 0; n < 20 && (k ? SLEEP_REQ : GENTLE_HALT) !== v; n++) @(posedge MCLK);
    endtask

    // Model: moves load target and parameters
    task automatic move(input logic [15:0] p, input logic [15:0] q);
        ep = p;
        eprm = q;
        fr(4'h4, lmcd_lin_master_i.pid(6'h25), {32'h0, q[15:8], q[7:0], p[7:0], p[15:8]});
    endtask

    task automatic t1(input logic b, input logic [6:0] ad, input logic [6:0] c);
        fr(4'h2, lmcd_lin_master_i.pid(6'h12), {48'h0, b, ad, 1'h1, c});
    endtask

    task automatic rst();
        @(posedge MCLK);
        RESET <= 1'h1;
        repeat (3) @(posedge MCLK);
        RESET <= 1'h0;
        apb(1'h1, 8'h00, 32'h15);
        apb(1'h1, 8'h04, 32'h1225);
    endtask

    task automatic sleep();
        fr(4'h8, 8'h3C, 64'hFFFFFFFFFFFFFF00);
    endtask

    task automatic tally_and_finish();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ==================================================================
    // Sequence
    initial begin
        rst();
        apb(1'h0, 8'h04, 32'h0);
        chk(rd, 32'h1225, "ids");
        apb(1'h0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        for (i = 0; i < 6; i++) begin
            move($random(seed), $random(seed));
            chk({STALL_THR_IDX, ACC_IDX, VMAX_IDX, VMIN_IDX, TARGET_POS}, {eprm, ep}, "move");
            apb(1'h0, 8'h10, 32'h0);
            chk(rd, eprm, "params reg");
        end
        fr(4'h4, lmcd_lin_master_i.pid(6'h25) ^ 8'h80, 64'h9ABCDEF0);
        chk(TARGET_POS, ep, "bad parity");
        fr(4'h3, lmcd_lin_master_i.pid(6'h25), 64'h9ABCDEF0);
        chk(TARGET_POS, ep, "bad length");
        fr(4'h4, lmcd_lin_master_i.pid(6'h26), 64'h9ABCDEF0);
        chk(TARGET_POS, ep, "other motor id");
        @(posedge MCLK);
        MOTION_BUSY <= 1'h1;
        ACT_POS <= 16'h0ABC;
        t1(1'h1, 7'h55, 7'h0F);
        chk(GENTLE_HALT, 1'h0, "other node");
        REF_RUN_BUSY <= 1'h1;
        t1(1'h0, 7'h55, 7'h0F);
        chk(GENTLE_HALT, 1'h0, "reference run");
        REF_RUN_BUSY <= 1'h0;
        t1(1'h0, 7'h55, 7'h0F);
        chk(GENTLE_HALT, 1'h1, "broadcast halt");
        repeat (5) @(posedge MCLK);
        chk(GENTLE_HALT, 1'h1, "halt held");
        MOTION_BUSY <= 1'h0;
        wt(1'h0, 1'h0);
        repeat (2) @(posedge MCLK);
        chk(TARGET_POS, 16'h0ABC, "hold position");
        SWI_I <= 1'h1;
        repeat (8) @(posedge MCLK);
        chk(SWI_LEVEL, 1'h1, "switch level");
        t1(1'h1, 7'h15, 7'h1F);
        chk(SWI_OE, 1'h1, "probe on");
        BEMF_IN <= 1'h1;
        SWI_I <= 1'h0;
        repeat (8) @(posedge MCLK);
        chk({SWI_O, SWI_LEVEL}, 2'h3, "probe out, level frozen");
        move(16'h1234, 16'h5678);
        chk(SWI_OE, 1'h1, "probe sticky");
        MOTION_BUSY <= 1'h1;
        OVER_TEMP <= 1'h1;
        wt(1'h0, 1'h1);
        chk(GENTLE_HALT, 1'h1, "thermal halt");
        MOTION_BUSY <= 1'h0;
        OVER_TEMP <= 1'h0;
        repeat (8) @(posedge MCLK);
        fr(4'h8, 8'h3C, 64'hFEFFFFFFFFFFFF00);
        chk(SLEEP_REQ, 1'h0, "bad sleep fill");
        sleep();
        chk(SLEEP_REQ, 1'h1, "sleep idle");
        rst();
        MOTION_BUSY <= 1'h1;
        SEC_POS <= 11'h523;
        sleep();
        chk({SLEEP_REQ, TARGET_POS}, {1'h0, {5{SEC_POS[10]}}, SEC_POS}, "secure reload");
        MOTION_BUSY <= 1'h0;
        wt(1'h1, 1'h1);
        chk(SLEEP_REQ, 1'h1, "sleep after move");
        rst();
        MOTION_BUSY <= 1'h1;
        SEC_POS <= 11'h400;
        ACT_POS <= 16'h0777;
        sleep();
        chk(GENTLE_HALT, 1'h1, "sleep halts");
        MOTION_BUSY <= 1'h0;
        wt(1'h1, 1'h1);
        chk({SLEEP_REQ, TARGET_POS}, {1'h1, 16'h0777}, "halt then sleep");
        tally_and_finish();
    end

    // Whole run is a few hundred cycles; this limit only catches a hang
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
